// >>> hdl/program_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "program_interrupt_control_regs.svh"
module program_interrupt_control
    import program_interrupt_control_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  cmdValid,
    input  wire command_type           cmd,
    input  wire logic [`IRQ_COUNT-1:0] irqPending,
    input  wire context_type           liveContext,
    input  wire logic                  engineIdle,
    output logic                       replyValid,
    output reply_type                  reply,
    output logic                       jumpValid,
    output logic [`PC_WIDTH-1:0]       jumpAddress,
    output logic                       restoreValid,
    output context_type                restoreContext,
    output logic [`IRQ_COUNT-1:0]      irqAck,
    output logic                       inHandler,
    output logic                       globalEnable,
    output logic [`IRQ_COUNT-1:0]      irqEnable
);
    // ------------------------------------------------------------
    // Dispatch state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_FETCH = 3'b010,
        S_JUMP  = 3'b100
    } state_type;

    state_type                   state;
    context_type                 savedContext;
    logic [`IRQ_INDEX_WIDTH-1:0] vecReadIndex;
    logic [`PC_WIDTH-1:0]        vecReadData;
    logic [`IRQ_COUNT-1:0]       eligible;
    logic [`IRQ_INDEX_WIDTH-1:0] firstIndex;
    logic                        anyEligible;
    logic                        isTypeGlobal;
    logic                        isEnable;
    logic                        isDisable;
    logic                        isVector;
    logic                        isReturn;
    logic                        startDispatch;
    logic                        endHandler;
    logic                        kindInTable;
    logic                        vecWrite;

    assign isTypeGlobal = (cmd.kind == `IRQ_GLOBAL_NUMBER);
    assign isEnable  = cmdValid && cmd.opcode == `OPC_ENABLE_IRQ;
    assign isDisable = cmdValid && cmd.opcode == `OPC_DISABLE_IRQ;
    assign isVector  = cmdValid && cmd.opcode == `OPC_SET_VECTOR;
    assign isReturn  = cmdValid && cmd.opcode == `OPC_RETURN_HANDLER;

    assign eligible = globalEnable ? (irqPending & irqEnable) : '0;

    // Lowest-numbered eligible source wins: the scan runs high to low
    always_comb begin
        firstIndex  = '0;
        anyEligible = 1'b0;
        for (int i = `IRQ_COUNT - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                firstIndex  = i[`IRQ_INDEX_WIDTH-1:0];
                anyEligible = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Enables
    // ------------------------------------------------------------
    // Number 255 is the global switch; 0 to 31 address single sources
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            globalEnable <= 1'b0;
        end else if (isEnable && isTypeGlobal) begin
            globalEnable <= 1'b1;
        end else if (isDisable && isTypeGlobal) begin
            globalEnable <= 1'b0;
        end
    end

    for (genvar g = 0; g < `IRQ_COUNT; g++) begin : g_enable
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                irqEnable[g] <= 1'b0;
            end else if (cmd.kind == 8'(g)) begin
                if (isEnable) begin
                    irqEnable[g] <= 1'b1;
                end else if (isDisable) begin
                    irqEnable[g] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    // Numbers outside the table have no slot; their vectors are dropped
    assign kindInTable = (cmd.kind[7:`IRQ_INDEX_WIDTH] == '0);
    assign vecWrite    = isVector && kindInTable;

    vector_table_mem u_vectors (
        .ref_clk     (ref_clk),
        .writeEnable (vecWrite),
        .writeIndex  (cmd.kind[`IRQ_INDEX_WIDTH-1:0]),
        .writeData   (cmd.value[`PC_WIDTH-1:0]),
        .readIndex   (vecReadIndex),
        .readData    (vecReadData)
    );

    // ------------------------------------------------------------
    // Dispatch and return
    // ------------------------------------------------------------
    // Dispatch only from idle, outside a handler and between engine
    // instructions, so a running instruction is never cut in two
    assign startDispatch = (state == S_IDLE) && !inHandler && anyEligible
        && engineIdle;
    assign endHandler = (state == S_IDLE) && isReturn && inHandler;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (startDispatch) begin
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    // The vector read is registered: one cycle to settle
                    state <= S_JUMP;
                end
                S_JUMP: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Handler flag: set by a dispatch, cleared by a return
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            inHandler <= 1'b0;
        end else if (startDispatch) begin
            inHandler <= 1'b1;
        end else if (endHandler) begin
            inHandler <= 1'b0;
        end
    end

    // Context captured at dispatch for the return to hand back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            savedContext <= '0;
        end else if (startDispatch) begin
            savedContext <= liveContext;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            restoreValid   <= 1'b0;
            restoreContext <= '0;
        end else begin
            restoreValid <= endHandler;
            if (endHandler) begin
                restoreContext <= savedContext;
            end
        end
    end

    // Acknowledge the lowest-numbered eligible source and latch its slot
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irqAck       <= '0;
            vecReadIndex <= '0;
        end else begin
            irqAck <= '0;
            if (startDispatch) begin
                irqAck       <= eligible & ~(eligible - 1'b1);
                vecReadIndex <= firstIndex;
            end
        end
    end

    // Jump: handler address once the table read has settled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            jumpValid   <= 1'b0;
            jumpAddress <= '0;
        end else begin
            jumpValid <= (state == S_JUMP);
            if (state == S_JUMP) begin
                jumpAddress <= vecReadData;
            end
        end
    end

    // ------------------------------------------------------------
    // Direct-mode reply
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            replyValid <= 1'b0;
            reply      <= '0;
        end else begin
            replyValid <= cmd.directMode
                && (isEnable || isDisable || isVector || isReturn);
            if (cmdValid) begin
                reply.status <= `STATUS_OK;
                reply.opcode <= cmd.opcode;
                reply.value  <= '0;
            end
        end
    end
endmodule // program_interrupt_control
`default_nettype wire

// >>> hdl/program_interrupt_control_pkg.sv
package program_interrupt_control_pkg;
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
        logic        directMode;
    } command_type;

    typedef struct packed {
        logic [31:0] accu;
        logic [31:0] xReg;
        logic [7:0]  flags;
        logic [15:0] pc;
    } context_type;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  opcode;
        logic [31:0] value;
    } reply_type;
endpackage

// >>> hdl/program_interrupt_control_regs.svh
// Functional notes
// - Opcode 25 enables the single interrupt named in type; rest ignored.
// - Opcode 25 with number 255 switches interrupt processing on globally.
// - Opcode 26 disables the single interrupt named in type; rest ignored.
// - Opcode 26 with number 255 switches all interrupt dispatch off globally.
// - Opcode 37 stores value as handler address for the interrupt in type.
// - A later vector command overwrites the stored handler address.
// - Opcode 38 ends the handler and resumes the interrupted program.
// - Return restores saved accumulator, X register, flags and PC.
`ifndef PROGRAM_INTERRUPT_CONTROL_REGS_SVH
`define PROGRAM_INTERRUPT_CONTROL_REGS_SVH
`define OPC_ENABLE_IRQ     8'h19
`define OPC_DISABLE_IRQ    8'h1a
`define OPC_SET_VECTOR     8'h25
`define OPC_RETURN_HANDLER 8'h26
`define IRQ_GLOBAL_NUMBER  8'hff
`define STATUS_OK          8'h64
`define IRQ_COUNT          32
`define IRQ_INDEX_WIDTH    5
`define PC_WIDTH           16
`endif

// >>> hdl/vector_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "program_interrupt_control_regs.svh"
module vector_table_mem (
    input  wire logic                        ref_clk,
    input  wire logic                        writeEnable,
    input  wire logic [`IRQ_INDEX_WIDTH-1:0] writeIndex,
    input  wire logic [`PC_WIDTH-1:0]        writeData,
    input  wire logic [`IRQ_INDEX_WIDTH-1:0] readIndex,
    output var  logic [`PC_WIDTH-1:0]        readData
);
    logic [`PC_WIDTH-1:0] entries [`IRQ_COUNT];

    always_ff @(posedge ref_clk) begin
        if (writeEnable) begin
            entries[writeIndex] <= writeData;
        end
    end

    always_ff @(posedge ref_clk) begin
        readData <= entries[readIndex];
    end
endmodule // vector_table_mem
`default_nettype wire

// >>> verification/command_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module command_host_model
    import program_interrupt_control_pkg::*; (
    input wire logic ref_clk, replyValid, input wire reply_type reply,
    output var logic cmdValid, output var command_type cmd);
    initial {cmdValid, cmd} = '0;
    task automatic send(logic [7:0] op, kd, logic dm, logic [15:0] v,
                        output logic got);
        @(negedge ref_clk);
        cmd = '{op, kd, 8'h5a, {16'ha5a5, v}, dm};
        cmdValid = 1'b1;
        @(negedge ref_clk);
        {cmdValid, cmd} = {1'b0, ~cmd};
        got = replyValid && reply.status == 8'h64 && reply.opcode == op;
    endtask
endmodule // command_host_model
`default_nettype wire

// >>> verification/program_interrupt_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module program_interrupt_control_checker
    import program_interrupt_control_pkg::*; (
    input wire logic ref_clk, rst_n, cmdValid, engineIdle, replyValid,
    input wire logic jumpValid, restoreValid, inHandler, globalEnable,
    input wire logic [31:0] irqPending, irqAck, irqEnable,
    input wire command_type cmd, input wire reply_type reply);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic en, dis, glob, take;
    assign en = cmdValid && cmd.opcode == 8'h19;
    assign dis = cmdValid && cmd.opcode == 8'h1a;
    assign glob = cmd.kind == 8'hff;
    assign take = globalEnable && !inHandler && |(irqEnable & irqPending);
    chk_reply_ok: assert property (
        cmd.directMode && (en || dis) |=> replyValid && reply.status == 8'h64)
        else $error("bad reply");
    chk_global_on: assert property (
        en && glob |=> globalEnable) else $error("no global on");
    chk_global_off: assert property (
        dis && glob |=> !globalEnable) else $error("no global off");
    chk_single_on: assert property (
        en && !cmd.kind[7:5] |=> irqEnable == ($past(irqEnable)
        | 32'h1 << $past(cmd.kind[4:0]))) else $error("bad enable");
    chk_single_off: assert property (
        dis && !cmd.kind[7:5] |=> irqEnable == ($past(irqEnable)
        & ~(32'h1 << $past(cmd.kind[4:0])))) else $error("bad disable");
    chk_ack_gated: assert property (
        |irqAck |-> $past(take) && $past(engineIdle)) else $error("bad ack");
    chk_jump_after: assert property (
        |irqAck |-> ##2 jumpValid) else $error("no jump");
    chk_return_ctx: assert property (
        cmdValid && cmd.opcode == 8'h26 && inHandler |=> restoreValid
        && !inHandler) else $error("no restore");
endmodule // program_interrupt_control_checker
bind program_interrupt_control program_interrupt_control_checker
    program_interrupt_control_checker_i (.*);
`default_nettype wire

// >>> verification/program_interrupt_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module program_interrupt_control_tb_top;
    import program_interrupt_control_pkg::*;
    localparam context_type CTX = 88'h12345678_9abcdef0_5c_0042;
    logic ref_clk = 1'b0, rst_n = 1'b0, engineIdle = 1'b1, got, globalEnable;
    logic cmdValid, replyValid, jumpValid, restoreValid, inHandler;
    logic [31:0] irqPending = '0, irqAck, irqEnable, ackSeen = '0;
    logic [15:0] jumpAddress;
    command_type cmd;
    reply_type reply;
    context_type liveContext = '0, restoreContext;
    int mismatches = 0, compares = 0, n;
    always #2.5 ref_clk = ~ref_clk;
    command_host_model command_host_model_i (.*);
    program_interrupt_control program_interrupt_control_i (.*);
    task automatic check(logic [127:0] act, exp);
        compares++;
        if (act !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, act, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic issue(logic [7:0] op, kd, logic dm, logic [15:0] v = 0);
        command_host_model_i.send(op, kd, dm, v, got);
        check(got, dm);
    endtask
    task automatic testEnables();
        issue(8'h19, 8'h03, 1'b1, 16'hffff);
        issue(8'h19, 8'h1f, 1'b1);
        issue(8'h1a, 8'h1f, 1'b1);
        issue(8'h19, 8'hff, 1'b1);
        check({globalEnable, irqEnable}, {1'b1, 32'h8});
        $display("test enables done");
    endtask
    task automatic testDispatch();
        liveContext = CTX;
        issue(8'h25, 8'h03, 1'b0, 16'h0050);
        issue(8'h25, 8'h03, 1'b0, 16'h0123);
        issue(8'h1a, 8'hff, 1'b1);
        irqPending = 32'h8;
        @(negedge ref_clk);
        check({inHandler, irqAck}, 33'h0);
        issue(8'h19, 8'hff, 1'b1);
        for (n = 0; n < 20 && jumpValid !== 1'b1; n++) begin
            @(negedge ref_clk);
            if (irqAck !== '0) ackSeen = irqAck;
        end
        check(n < 20, 1'b1);
        if (n == 20) end_of_test();
        check(ackSeen, 32'h8);
        {irqPending, liveContext} = '1;
        check({inHandler, jumpAddress}, {1'b1, 16'h0123});
        issue(8'h26, 8'hff, 1'b0);
        check(restoreContext, CTX);
        check({restoreValid, inHandler}, 2'b10);
        $display("test dispatch done");
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        testEnables();
        testDispatch();
        end_of_test();
    end
endmodule // program_interrupt_control_tb_top
`default_nettype wire
